/* File: dv/usct_peer.sv */
// remote serial peer: sends one frame on the receive line per send pulse
// assumes divisor 0, normal speed: 16 clocks per bit
`timescale 1ns/1ps
module usct_peer (
    // clock
    input wire clk,
    // frame request
    input wire send,
    input wire [7:0] value,
    input wire [1:0] stops,
    // lines toward the block
    output logic rxd_in = 1'b1,
    output logic xck_in = 1'b0
);
    // ==========================================
    // sender; xck_in stands still, far below a quarter of clk
    integer i;
    logic [10:0] f;
    always @(posedge clk) begin
        if (send) begin
            f = {stops, value, 1'b0};
            for (i = 0; i < 11; i = i + 1) begin
                rxd_in <= f[i];
                repeat (16) @(posedge clk);
            end
            rxd_in <= 1'b1;
        end
    end
endmodule

/* File: dv/usct_props.sv */
// checker for usct_top, watching its ports only
// assumes one clock domain with a synchronous active-high reset
`timescale 1ns/1ps
module usct_checker #(
    parameter DIV_W = 12
) (
    // clock and reset
    input wire clk,
    input wire rst,
    // configuration
    input wire baud_low_wr,
    input wire [7:0] baud_low_wdata,
    input wire shared_wr,
    input wire [7:0] shared_wdata,
    input wire [DIV_W-1:0] baud_divisor,
    input wire [6:0] control_status_c,
    input wire transmit_enable_bit,
    input wire transfer_clock_direction,
    // transmit path and pins
    input wire data_valid,
    input wire data_ready,
    input wire buffer_empty_flag,
    input wire transmit_complete_flag,
    input wire txd_out,
    input wire txd_oe_n,
    input wire xck_oe_n
);
    // ==========================================
    // properties
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    a_sel_ctrl: assert property (shared_wr && shared_wdata[7] |=>
        control_status_c == $past(shared_wdata[6:0])) else $error("control write lost");
    a_sel_div: assert property (shared_wr && !shared_wdata[7] |=>
        baud_divisor[DIV_W-1:8] == $past(shared_wdata[3:0]) && $stable(control_status_c))
        else $error("divisor high write wrong");
    a_low_div: assert property (baud_low_wr |=>
        baud_divisor[7:0] == $past(baud_low_wdata)) else $error("divisor low write wrong");
    a_push_empty: assert property (data_valid && data_ready |=> !buffer_empty_flag)
        else $error("empty flag after push");
    a_full_empty: assert property (!data_ready |-> !buffer_empty_flag)
        else $error("full and empty");
    a_txc_rise: assert property ($rose(transmit_complete_flag) |-> buffer_empty_flag)
        else $error("complete with data waiting");
    a_idle_high: assert property (txd_oe_n |-> txd_out)
        else $error("released line not high");
    a_oe_enable: assert property (transmit_enable_bit |-> !txd_oe_n)
        else $error("data pin not taken");
    a_xck_master: assert property ((control_status_c[6] && transfer_clock_direction
        && transmit_enable_bit) [*2] |-> !xck_oe_n) else $error("clock pin not driven");
    a_xck_slave: assert property (!transfer_clock_direction [*2] |-> xck_oe_n)
        else $error("slave drives clock pin");
endmodule
bind usct_top usct_checker #(.DIV_W(DIV_W)) u_chk (.clk(clk), .rst(rst),
    .baud_low_wr(baud_low_wr), .baud_low_wdata(baud_low_wdata), .shared_wr(shared_wr),
    .shared_wdata(shared_wdata), .baud_divisor(baud_divisor),
    .control_status_c(control_status_c), .transmit_enable_bit(transmit_enable_bit),
    .transfer_clock_direction(transfer_clock_direction), .data_valid(data_valid),
    .data_ready(data_ready), .buffer_empty_flag(buffer_empty_flag),
    .transmit_complete_flag(transmit_complete_flag), .txd_out(txd_out),
    .txd_oe_n(txd_oe_n), .xck_oe_n(xck_oe_n));

/* File: dv/usct_top_tb.sv */
// testbench for usct_top: config, framing, buffer fill, pins, receive
// assumes the peer model drives the receive and clock pins
`timescale 1ns/1ps
`define CHK(n, e, g) begin n_checks++; if ((g) !== (e)) begin error_cnt++; \
    $display("unexpected %s exp %h got %h", n, e, g); end end
module usct_top_tb;
    logic clk, rst, baud_low_wr, shared_wr, double_speed_bit, transmit_enable_bit, send;
    logic receive_enable_bit, transfer_clock_direction, char_size_bit2, txc_clear, data_valid;
    logic [7:0] baud_low_wdata, shared_wdata, value;
    logic [8:0] data_wdata, rx_data;
    logic [11:0] baud_divisor;
    logic [6:0] control_status_c;
    logic data_ready, buffer_empty_flag, transmit_complete_flag, rx_valid, framing_error_flag;
    logic txd_out, txd_oe_n, rxd_in, xck_in, xck_out, xck_oe_n;
    logic [1:0] stops;
    integer error_cnt = 0, n_checks = 0, cyc = 0;
    usct_top uut (.clk, .rst, .baud_low_wr, .baud_low_wdata, .shared_wr, .shared_wdata,
        .double_speed_bit, .transmit_enable_bit, .receive_enable_bit,
        .transfer_clock_direction, .char_size_bit2, .txc_clear, .data_valid, .data_wdata,
        .data_ready, .buffer_empty_flag, .transmit_complete_flag, .baud_divisor,
        .control_status_c, .rx_data, .rx_valid, .framing_error_flag, .txd_out, .txd_oe_n,
        .rxd_in, .xck_in, .xck_out, .xck_oe_n);
    usct_peer peer (.clk, .send, .value, .stops, .rxd_in, .xck_in);
    // ==========================================
    // clock, timeout, verdict
    initial begin
        clk = 0;
        forever #12.5 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            error_cnt++;
            summarize;
        end
    end
    task summarize;
        $display("checks %0d mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // ==========================================
    // drivers and line monitor
    task cw(input sel, input [7:0] v);
        @(posedge clk);
        shared_wr <= sel;
        baud_low_wr <= !sel;
        shared_wdata <= v;
        baud_low_wdata <= v;
        @(posedge clk);
        shared_wr <= 0;
        baud_low_wr <= 0;
        #1;
    endtask
    task push(input [8:0] d);
        @(posedge clk);
        data_valid <= 1;
        data_wdata <= d;
        @(posedge clk);
        while (data_ready !== 1'b1) @(posedge clk);
        data_valid <= 0;
    endtask
    task wait_fall(input integer lim);
        integer k;
        k = 0;
        #1;
        while (txd_out !== 1'b0 && k < lim) begin
            @(posedge clk);
            #1;
            k++;
        end
    endtask
    task bits(input [8:0] d, input integer n, input [1:0] pm, input two, input integer bp);
        integer j, k;
        logic [12:0] f;
        f = 13'h1fff;
        f[0] = 1'b0;
        for (j = 0; j < n; j++) f[j+1] = d[j];
        k = n + 1;
        if (pm[1]) begin
            f[k] = ^(d & ((9'h1 << n) - 1)) ^ pm[0];
            k++;
        end
        k = k + 1 + two;
        for (j = 0; j < k; j++) begin
            `CHK("txd bit", f[j], txd_out)
            if (j < k - 1) begin
                repeat (bp) @(posedge clk);
                #1;
            end
        end
    endtask
    task frame(input [8:0] d, input integer n, input [1:0] pm, input two, input integer bp);
        wait_fall(40);
        repeat (bp / 2) @(posedge clk);
        #1;
        bits(d, n, pm, two, bp);
        repeat (bp) @(posedge clk);
        #1;
    endtask
    // ==========================================
    // scenarios
    task s_cfg;
        `CHK("divisor", 12'h000, baud_divisor)
        `CHK("control", 7'h06, control_status_c)
        `CHK("empty", 1'b1, buffer_empty_flag)
        cw(1, 8'h0f);
        cw(0, 8'hff);
        `CHK("divisor", 12'hfff, baud_divisor)
        cw(1, 8'h87);
        `CHK("divisor", 12'hfff, baud_divisor)
        `CHK("control", 7'h07, control_status_c)
        cw(1, 8'h00);
        cw(0, 8'h00);
    endtask
    task s_tx;
        @(posedge clk);
        transmit_enable_bit <= 1;
        push(9'h1a5);
        frame(9'h1a5, 8, 2'b00, 0, 16);
        `CHK("complete", 1'b1, transmit_complete_flag)
        `CHK("txd idle", 1'b1, txd_out)
        @(posedge clk);
        txc_clear <= 1;
        @(posedge clk);
        txc_clear <= 0;
        #1;
        `CHK("complete", 1'b0, transmit_complete_flag)
        cw(1, 8'ha8);
        push(9'h1f3);
        frame(9'h1f3, 5, 2'b10, 1, 16);
        char_size_bit2 <= 1;
        cw(1, 8'hb6);
        push(9'h155);
        frame(9'h155, 9, 2'b11, 0, 16);
        char_size_bit2 <= 0;
        double_speed_bit <= 1;
        cw(1, 8'h86);
        push(9'h03c);
        frame(9'h03c, 8, 2'b00, 0, 8);
        double_speed_bit <= 0;
    endtask
    // shifter busy with 11, so 22 and 33 fill both entries
    task s_fill;
        push(9'h011);
        wait_fall(40);
        @(posedge clk);
        data_valid <= 1;
        data_wdata <= 9'h022;
        @(posedge clk);
        data_wdata <= 9'h033;
        @(posedge clk);
        data_valid <= 0;
        #1;
        `CHK("ready", 1'b0, data_ready)
        `CHK("empty", 1'b0, buffer_empty_flag)
        repeat (5) @(posedge clk);
        #1;
        bits(9'h011, 8, 2'b00, 0, 16);
        wait_fall(12);
        repeat (8) @(posedge clk);
        #1;
        bits(9'h022, 8, 2'b00, 0, 16);
        frame(9'h033, 8, 2'b00, 0, 16);
        `CHK("empty", 1'b1, buffer_empty_flag)
    endtask
    task s_sync;
        logic x;
        cw(1, 8'hc6);
        @(posedge clk);
        #1;
        `CHK("xck oe", 1'b0, xck_oe_n)
        x = xck_out;
        @(posedge clk);
        #1;
        `CHK("xck out", ~x, xck_out)
        transfer_clock_direction <= 0;
        repeat (2) @(posedge clk);
        #1;
        `CHK("xck oe", 1'b1, xck_oe_n)
        transfer_clock_direction <= 1;
        cw(1, 8'h8e);
    endtask
    task rx(input [7:0] v, input [1:0] s, input fe);
        integer k;
        @(posedge clk);
        send <= 1;
        value <= v;
        stops <= s;
        @(posedge clk);
        send <= 0;
        k = 0;
        #1;
        while (rx_valid !== 1'b1 && k < 300) begin
            @(posedge clk);
            #1;
            k++;
        end
        `CHK("rx data", {1'b0, v}, rx_data)
        `CHK("framing", fe, framing_error_flag)
        repeat (250) @(posedge clk);
    endtask
    // ==========================================
    // main sequence
    initial begin
        rst = 1;
        {baud_low_wr, shared_wr, double_speed_bit, transmit_enable_bit, send} = 0;
        {char_size_bit2, txc_clear, data_valid, baud_low_wdata, shared_wdata} = 0;
        {value, data_wdata} = 0;
        receive_enable_bit = 1;
        transfer_clock_direction = 1;
        stops = 2'b11;
        repeat (3) @(posedge clk);
        rst <= 0;
        @(posedge clk);
        #1;
        s_cfg;
        s_tx;
        s_fill;
        s_sync;
        rx(8'h3c, 2'b01, 1'b0);
        rx(8'hc3, 2'b10, 1'b1);
        summarize;
    end
endmodule

/* File: hw/usct_defines.vh */
// constants for the serial transceiver clocking, framing and transmit block
// assumes inclusion by bare name from the design file
`ifndef USCT_DEFINES_VH
`define USCT_DEFINES_VH
// divisor width, low byte width
`define USCT_DIV_W 12
`define USCT_LOW_W 8
// shared location layout: select flag on top, control fields below
`define USCT_SEL_BIT 7
`define USCT_MODE_BIT 6
`define USCT_PM_HI 5
`define USCT_PM_LO 4
`define USCT_STOP_BIT 3
`define USCT_CSZ_HI 2
`define USCT_CSZ_LO 1
`define USCT_CPOL_BIT 0
`define USCT_CTRL_W 7
// reset: async, no parity, one stop, 8 data bits, polarity 0
`define USCT_CTRL_RST 7'h06
// oversampling: last count and half-bit start value
`define USCT_OS_NORM 4'hf
`define USCT_OS_DBL 4'h7
`define USCT_HALF_NORM 4'h8
`define USCT_HALF_DBL 4'h4
// character sizes
`define USCT_MIN_BITS 4'h5
`define USCT_MAX_BITS 4'h9
`define USCT_DATA_W 9
// frame: start + 9 data + parity + 2 stop
`define USCT_FRM_W 13
`define USCT_FRM_OVH 4'h2
// transmit buffer
`define USCT_BUF_FULL 2'h2
`endif

/* File: hw/usct_top.v */
// serial transceiver: baud generator, transfer clock, framing, transmitter,
// two-entry transmit buffer and a compact receiver with framing check
// assumes configuration strobes come from logic on clk; pins are asynchronous
//
// Summary of operation
// - twelve-bit baud divisor from two bytes
// - double speed halves transmit divisor, async only
// - double speed receiver uses eight samples
// - slave clock synchronised then edge detected
// - sync mode: clock pin output or input
// - sample on edge opposite data change
// - polarity bit selects change and sample edges
// - thirty formats: 5-9 data, parity, stops
// - start, data lsb first, parity, stops
// - start low, stops high, idle high
// - one format setting shared by both directions
// - second stop ignored; error on first
// - even parity xor, odd inverted
// - shared location: select bit picks control
// - transmit enable hands data pin to block
// - sync master transmit takes over clock pin
// - buffer moves to shifter when idle/frame end
// - unused upper data bits ignored
// - down-counter reload on zero or low write
// - mode select async/sync; direction master/slave
// - empty flag while buffer holds nothing
// - complete flag after frame, buffer empty
`timescale 1ns/1ps
`include "usct_defines.vh"

module usct_top #(
    parameter DIV_W = `USCT_DIV_W
) (
    // clock and reset
    input wire clk,
    input wire rst,
    // configuration writes
    input wire baud_low_wr,
    input wire [7:0] baud_low_wdata,
    input wire shared_wr,
    input wire [7:0] shared_wdata,
    // control bits
    input wire double_speed_bit,
    input wire transmit_enable_bit,
    input wire receive_enable_bit,
    input wire transfer_clock_direction,
    input wire char_size_bit2,
    input wire txc_clear,
    // transmit data
    input wire data_valid,
    input wire [8:0] data_wdata,
    output wire data_ready,
    // status
    output wire buffer_empty_flag,
    output wire transmit_complete_flag,
    output wire [DIV_W-1:0] baud_divisor,
    output wire [6:0] control_status_c,
    // receive
    output wire [8:0] rx_data,
    output wire rx_valid,
    output wire framing_error_flag,
    // pins
    output wire txd_out,
    output wire txd_oe_n,
    input wire rxd_in,
    input wire xck_in,
    output wire xck_out,
    output wire xck_oe_n
);

localparam RX_IDLE = 2'h0;
localparam RX_START = 2'h1;
localparam RX_DATA = 2'h2;
localparam RX_STOP = 2'h3;

// ==========================================
// configuration
reg [`USCT_LOW_W-1:0] divl_q;
reg [DIV_W-`USCT_LOW_W-1:0] divh_q;
reg [`USCT_CTRL_W-1:0] ctl_q;

always @(posedge clk) begin
    if (rst) begin
        divl_q <= {`USCT_LOW_W{1'b0}};
        divh_q <= {(DIV_W-`USCT_LOW_W){1'b0}};
        ctl_q <= `USCT_CTRL_RST;
    end else begin
        if (baud_low_wr) begin
            divl_q <= baud_low_wdata;
        end
        if (shared_wr) begin
            if (shared_wdata[`USCT_SEL_BIT]) begin
                ctl_q <= shared_wdata[`USCT_CTRL_W-1:0];
            end else begin
                divh_q <= shared_wdata[DIV_W-`USCT_LOW_W-1:0];
            end
        end
    end
end

assign baud_divisor = {divh_q, divl_q};
assign control_status_c = ctl_q;

wire sync_m = ctl_q[`USCT_MODE_BIT];
wire master = transfer_clock_direction;
wire cpol = ctl_q[`USCT_CPOL_BIT];
wire [1:0] pm = ctl_q[`USCT_PM_HI:`USCT_PM_LO];
wire stop2 = ctl_q[`USCT_STOP_BIT];
wire [1:0] csz = ctl_q[`USCT_CSZ_HI:`USCT_CSZ_LO];
wire [3:0] nbits = char_size_bit2 ? `USCT_MAX_BITS : `USCT_MIN_BITS + {2'b00, csz};
// double speed is forced off in sync so a stray setting cannot skew the clock
wire dbl = double_speed_bit & ~sync_m;
wire [3:0] os_last = dbl ? `USCT_OS_DBL : `USCT_OS_NORM;
wire [3:0] os_half = dbl ? `USCT_HALF_DBL : `USCT_HALF_NORM;

// ==========================================
// baud generator
reg [DIV_W-1:0] cnt_q;
wire tick = cnt_q == {DIV_W{1'b0}};
// a low-byte write restarts the count with the new value at once
wire [DIV_W-1:0] div_ld = {divh_q, baud_low_wr ? baud_low_wdata : divl_q};

always @(posedge clk) begin
    if (rst) begin
        cnt_q <= {DIV_W{1'b0}};
    end else if (baud_low_wr || tick) begin
        cnt_q <= div_ld;
    end else begin
        cnt_q <= cnt_q - 1'b1;
    end
end

// ==========================================
// pin synchronisers and transfer clock
reg [2:0] xs_q;
reg [2:0] rs_q;
reg xf_q;
reg xp_q;
reg rxf_q;
reg mx_q;

always @(posedge clk) begin
    if (rst) begin
        xs_q <= 3'h0;
        rs_q <= 3'h7;
        xf_q <= 1'b0;
        xp_q <= 1'b0;
        rxf_q <= 1'b1;
        mx_q <= 1'b0;
    end else begin
        xs_q <= {xs_q[1:0], xck_in};
        rs_q <= {rs_q[1:0], rxd_in};
        if (xs_q[1] == xs_q[2]) begin
            xf_q <= xs_q[2];
        end
        if (rs_q[1] == rs_q[2]) begin
            rxf_q <= rs_q[2];
        end
        xp_q <= xf_q;
        if (sync_m && master && tick) begin
            mx_q <= ~mx_q;
        end
    end
end

// master edges are predicted one clock ahead so data moves with the pin
wire rise = master ? (tick & ~mx_q) : (xf_q & ~xp_q);
wire fall = master ? (tick & mx_q) : (~xf_q & xp_q);
wire chg = cpol ? fall : rise;
wire smp = cpol ? rise : fall;

// ==========================================
// transmit bit timing
reg [3:0] txo_q;
wire async_stb = tick & (txo_q == os_last);
wire bit_stb = sync_m ? chg : async_stb;

always @(posedge clk) begin
    if (rst) begin
        txo_q <= 4'h0;
    end else if (tick) begin
        txo_q <= async_stb ? 4'h0 : txo_q + 1'b1;
    end
end

// ==========================================
// two-entry transmit buffer
reg fwp_q;
reg frp_q;
reg [1:0] fcnt_q;
wire ld;
wire fnemp = fcnt_q != 2'h0;
assign data_ready = fcnt_q != `USCT_BUF_FULL;
wire push = data_valid & data_ready;
assign buffer_empty_flag = ~fnemp;

genvar g;
generate
    for (g = 0; g < 2; g = g + 1) begin : ent
        reg [`USCT_DATA_W-1:0] q;
        always @(posedge clk) begin
            if (rst) begin
                q <= {`USCT_DATA_W{1'b0}};
            end else if (push && (fwp_q == g)) begin
                q <= data_wdata;
            end
        end
    end
endgenerate

wire [`USCT_DATA_W-1:0] head = frp_q ? ent[1].q : ent[0].q;

always @(posedge clk) begin
    if (rst) begin
        fwp_q <= 1'b0;
        frp_q <= 1'b0;
        fcnt_q <= 2'h0;
    end else begin
        if (push) begin
            fwp_q <= ~fwp_q;
        end
        if (ld) begin
            frp_q <= ~frp_q;
        end
        if (push && !ld) begin
            fcnt_q <= fcnt_q + 1'b1;
        end else if (ld && !push) begin
            fcnt_q <= fcnt_q - 1'b1;
        end
    end
end

// ==========================================
// frame composition
reg [`USCT_FRM_W-1:0] frm;
reg par;
integer i;

always @* begin
    frm = {`USCT_FRM_W{1'b1}};
    frm[0] = 1'b0;
    par = pm[0];
    for (i = 0; i < `USCT_DATA_W; i = i + 1) begin
        if (i < nbits) begin
            frm[i+1] = head[i];
            par = par ^ head[i];
        end
    end
    if (pm[1]) begin
        frm[nbits+1'b1] = par;
    end
end

wire [3:0] flen = nbits + `USCT_FRM_OVH + {3'h0, pm[1]} + {3'h0, stop2};

// ==========================================
// transmit shifter
reg [`USCT_FRM_W-1:0] sh_q;
reg [3:0] rem_q;
reg busy_q;
reg txc_q;
wire last = busy_q & (rem_q == 4'h1);
assign ld = bit_stb & fnemp & (~busy_q | last);

always @(posedge clk) begin
    if (rst) begin
        sh_q <= {`USCT_FRM_W{1'b1}};
        rem_q <= 4'h0;
        busy_q <= 1'b0;
        txc_q <= 1'b0;
    end else begin
        if (ld) begin
            sh_q <= frm;
            rem_q <= flen;
            busy_q <= 1'b1;
        end else if (bit_stb && busy_q) begin
            sh_q <= {1'b1, sh_q[`USCT_FRM_W-1:1]};
            rem_q <= rem_q - 1'b1;
            if (last) begin
                busy_q <= 1'b0;
            end
        end
        // a completion in the clear cycle wins
        if (bit_stb && last && !fnemp) begin
            txc_q <= 1'b1;
        end else if (txc_clear) begin
            txc_q <= 1'b0;
        end
    end
end

assign transmit_complete_flag = txc_q;
assign txd_out = sh_q[0];
// disabling waits for pending data so no frame is cut short
wire tx_on = transmit_enable_bit | busy_q | fnemp;
assign txd_oe_n = ~tx_on;
assign xck_out = mx_q;
assign xck_oe_n = ~(sync_m & master & (tx_on | receive_enable_bit));

// ==========================================
// receiver
reg [1:0] rst_q;
reg [3:0] ros_q;
reg [3:0] rbit_q;
reg [`USCT_DATA_W-1:0] rsh_q;
reg [`USCT_DATA_W-1:0] rxd_q;
reg rxv_q;
reg fe_q;
wire [3:0] rxlen = nbits + {3'h0, pm[1]};
wire rstb = sync_m ? smp : (tick & (ros_q == os_last));

always @(posedge clk) begin
    if (rst) begin
        rst_q <= RX_IDLE;
        ros_q <= 4'h0;
        rbit_q <= 4'h0;
        rsh_q <= {`USCT_DATA_W{1'b0}};
        rxd_q <= {`USCT_DATA_W{1'b0}};
        rxv_q <= 1'b0;
        fe_q <= 1'b0;
    end else begin
        rxv_q <= 1'b0;
        if (tick) begin
            ros_q <= (ros_q == os_last) ? 4'h0 : ros_q + 1'b1;
        end
        case (rst_q)
            RX_IDLE: begin
                rbit_q <= 4'h0;
                rsh_q <= {`USCT_DATA_W{1'b0}};
                if (receive_enable_bit && !rxf_q) begin
                    if (!sync_m) begin
                        rst_q <= RX_START;
                        ros_q <= os_half;
                    end else if (smp) begin
                        rst_q <= RX_DATA;
                    end
                end
            end
            RX_START: begin
                if (rstb) begin
                    rst_q <= rxf_q ? RX_IDLE : RX_DATA;
                end
            end
            RX_DATA: begin
                if (rstb) begin
                    if (rbit_q < nbits) begin
                        rsh_q[rbit_q] <= rxf_q;
                    end
                    rbit_q <= rbit_q + 1'b1;
                    if (rbit_q == rxlen - 1'b1) begin
                        rst_q <= RX_STOP;
                    end
                end
            end
            RX_STOP: begin
                if (rstb) begin
                    fe_q <= ~rxf_q;
                    rxd_q <= rsh_q;
                    rxv_q <= 1'b1;
                    rst_q <= RX_IDLE;
                end
            end
            default: begin
                rst_q <= RX_IDLE;
            end
        endcase
    end
end

assign rx_data = rxd_q;
assign rx_valid = rxv_q;
assign framing_error_flag = fe_q;

endmodule
